// file: design/adcctl_top.sv
// converter control registers, channel sequencer and result words
`timescale 1ns/1ps
`default_nettype none
module adcctl_top #(
  parameter int WIDTH = 16
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic REG_RESET_CMD,
  input wire logic WATCHDOG_EXPIRED,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WRITE,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_READ,
  output logic [7:0] REG_RDATA,
  input wire logic DONE_MASK,
  input wire logic DISCHARGE_SENSE_ENABLE,
  output logic CONV_ENABLE,
  output logic [1:0] CONV_SPEED,
  output logic [3:0] CONV_BITS,
  output logic CONV_START,
  output logic [3:0] CONV_CHANNEL,
  input wire logic CONV_DONE,
  input wire logic [WIDTH-1:0] CONV_DATA,
  output logic PASS_DONE,
  output logic HOST_ALERT
);
  import adcctl_pkg::*;

  // channel numbers on the converter mux: 0..6 first byte bits 7..1, 7..10 second byte bits 7..4
  localparam logic [3:0] LAST_CHANNEL = 4'ha;

  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] dis0_reg, dis0_next;
  logic [7:0] dis1_reg, dis1_next;
  logic [WIDTH-1:0] res_reg [NUM_RESULTS];
  logic [WIDTH-1:0] res_next [NUM_RESULTS];
  logic [NUM_RESULTS-1:0] seeded_reg, seeded_next;
  adcctl_state_e state_reg, state_next;
  logic [3:0] chan_reg, chan_next;
  logic start_reg, start_next;
  logic alert_reg, alert_next;
  logic passdone_reg, passdone_next;
  logic [7:0] rdata_reg, rdata_next;
  logic done_s1, done_s2;
  logic [WIDTH-1:0] data_s1, data_s2;
  logic [WIDTH-1:0] filt;
  logic [WIDTH-1:0] sample_fix;
  logic res_slot_valid;
  logic [1:0] res_slot;

  function automatic logic chan_off(input logic [3:0] ch, input logic [7:0] d0,
                                    input logic [7:0] d1);
    if (ch <= 4'h6) begin
      chan_off = d0[3'(7 - ch)];
    end else begin
      chan_off = d1[3'(14 - ch)];
    end
  endfunction

  // maps a converter channel to its result slot, if held here
  function automatic logic [2:0] slot_of(input logic [3:0] ch);
    if (ch == 4'h0) begin
      slot_of = {1'b1, 2'(CH_INPUT_CURRENT)};
    end else if (ch == 4'h1) begin
      slot_of = {1'b1, 2'(CH_BATTERY_CURRENT)};
    end else if (ch == 4'h2) begin
      slot_of = {1'b1, 2'(CH_BUS_VOLTAGE)};
    end else if (ch == 4'ha) begin
      slot_of = {1'b1, 2'(CH_SOURCE_ONE)};
    end else begin
      slot_of = 3'b000;
    end
  endfunction

  function automatic logic [3:0] next_enabled(input logic [3:0] from, input logic [7:0] d0,
                                              input logic [7:0] d1);
    logic [3:0] c;
    c = 4'hf;
    for (int i = 10; i >= 0; i--) begin
      if (4'(i) >= from && !chan_off(4'(i), d0, d1)) begin
        c = 4'(i);
      end
    end
    next_enabled = c;
  endfunction

  // converter outputs cross from the analog side; synchronise before use
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      done_s1 <= CONV_DONE;
      done_s2 <= done_s1;
      data_s1 <= CONV_DATA;
      data_s2 <= data_s1;
    end
  end

  assign {res_slot_valid, res_slot} = slot_of(chan_reg);

  // battery current clamps discharge to zero while sensing is off
  always_comb begin
    sample_fix = data_s2;
    if (res_slot == 2'(CH_BATTERY_CURRENT) && !DISCHARGE_SENSE_ENABLE && data_s2[WIDTH-1]) begin
      sample_fix = '0;
    end
  end

  adcctl_average #(
    .WIDTH(WIDTH),
    .SHIFT(AVG_SHIFT)
  ) u_avg (
    .old_value(res_reg[res_slot]),
    .sample(sample_fix),
    .averaging(ctrl_reg[BIT_AVERAGING_SELECT]),
    .seed_fresh(ctrl_reg[BIT_AVERAGE_SEED_SELECT]),
    .first_pass(!seeded_reg[res_slot]),
    .result(filt)
  );

  // register file and sequencer next state
  always_comb begin
    ctrl_next = ctrl_reg;
    dis0_next = dis0_reg;
    dis1_next = dis1_reg;
    res_next = res_reg;
    seeded_next = seeded_reg;
    state_next = state_reg;
    chan_next = chan_reg;
    start_next = 1'b0;
    alert_next = 1'b0;
    passdone_next = 1'b0;
    rdata_next = rdata_reg;

    if (REG_WRITE) begin
      if (REG_ADDR == ADDR_CONVERTER_CONTROL) begin
        ctrl_next = REG_WDATA & MASK_CONVERTER_CONTROL;
        seeded_next = '0;
      end else if (REG_ADDR == ADDR_CHANNEL_DISABLE_FIRST) begin
        dis0_next = REG_WDATA & MASK_CHANNEL_DISABLE_FIRST;
      end else if (REG_ADDR == ADDR_CHANNEL_DISABLE_SECOND) begin
        dis1_next = REG_WDATA & MASK_CHANNEL_DISABLE_SECOND;
      end
    end

    if (REG_READ) begin
      if (REG_ADDR == ADDR_CONVERTER_CONTROL) begin
        rdata_next = ctrl_reg;
      end else if (REG_ADDR == ADDR_CHANNEL_DISABLE_FIRST) begin
        rdata_next = dis0_reg;
      end else if (REG_ADDR == ADDR_CHANNEL_DISABLE_SECOND) begin
        rdata_next = dis1_reg;
      end else if (REG_ADDR == ADDR_INPUT_CURRENT_RESULT) begin
        rdata_next = res_reg[CH_INPUT_CURRENT][15:8];
      end else if (REG_ADDR == ADDR_INPUT_CURRENT_RESULT + 8'h01) begin
        rdata_next = res_reg[CH_INPUT_CURRENT][7:0];
      end else if (REG_ADDR == ADDR_BATTERY_CURRENT_RESULT) begin
        rdata_next = res_reg[CH_BATTERY_CURRENT][15:8];
      end else if (REG_ADDR == ADDR_BATTERY_CURRENT_RESULT + 8'h01) begin
        rdata_next = res_reg[CH_BATTERY_CURRENT][7:0];
      end else if (REG_ADDR == ADDR_BUS_VOLTAGE_RESULT) begin
        rdata_next = res_reg[CH_BUS_VOLTAGE][15:8];
      end else if (REG_ADDR == ADDR_BUS_VOLTAGE_RESULT + 8'h01) begin
        rdata_next = res_reg[CH_BUS_VOLTAGE][7:0];
      end else if (REG_ADDR == ADDR_SOURCE_ONE_VOLTAGE_RESULT) begin
        rdata_next = res_reg[CH_SOURCE_ONE][15:8];
      end else if (REG_ADDR == ADDR_SOURCE_ONE_VOLTAGE_RESULT + 8'h01) begin
        rdata_next = res_reg[CH_SOURCE_ONE][7:0];
      end else begin
        rdata_next = 8'h00;
      end
    end

    case (state_reg)
      ADCCTL_IDLE: begin
        if (ctrl_reg[BIT_CONV_ON]) begin
          chan_next = next_enabled(4'h0, dis0_reg, dis1_reg);
          if (next_enabled(4'h0, dis0_reg, dis1_reg) != 4'hf) begin
            state_next = ADCCTL_START;
          end
        end
      end
      ADCCTL_START: begin
        start_next = ctrl_reg[BIT_CONV_ON];
        state_next = ctrl_reg[BIT_CONV_ON] ? ADCCTL_WAIT : ADCCTL_IDLE;
      end
      ADCCTL_WAIT: begin
        if (!ctrl_reg[BIT_CONV_ON]) begin
          state_next = ADCCTL_IDLE;
        end else if (done_s2) begin
          if (res_slot_valid) begin
            res_next[res_slot] = filt;
            seeded_next[res_slot] = 1'b1;
          end
          state_next = ADCCTL_NEXT;
        end
      end
      ADCCTL_NEXT: begin
        if (!done_s2) begin
          if (chan_reg < LAST_CHANNEL &&
              next_enabled(chan_reg + 4'h1, dis0_reg, dis1_reg) != 4'hf) begin
            chan_next = next_enabled(chan_reg + 4'h1, dis0_reg, dis1_reg);
            state_next = ADCCTL_START;
          end else begin
            passdone_next = 1'b1;
            state_next = ADCCTL_IDLE;
            if (ctrl_reg[BIT_RATE_SELECT]) begin
              ctrl_next[BIT_CONV_ON] = 1'b0;
              alert_next = !DONE_MASK;
            end
          end
        end
      end
      default: begin
        state_next = ADCCTL_IDLE;
      end
    endcase

    if (WATCHDOG_EXPIRED) begin
      ctrl_next[BIT_CONV_ON] = 1'b0;
    end
    if (REG_RESET_CMD) begin
      ctrl_next = RST_CONVERTER_CONTROL;
      dis0_next = RST_CHANNEL_DISABLE;
      dis1_next = RST_CHANNEL_DISABLE;
      seeded_next = '0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl_reg <= RST_CONVERTER_CONTROL;
      dis0_reg <= RST_CHANNEL_DISABLE;
      dis1_reg <= RST_CHANNEL_DISABLE;
      for (int i = 0; i < NUM_RESULTS; i++) begin
        res_reg[i] <= RST_RESULT;
      end
      seeded_reg <= '0;
      state_reg <= ADCCTL_IDLE;
      chan_reg <= 4'h0;
      start_reg <= 1'b0;
      alert_reg <= 1'b0;
      passdone_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      dis0_reg <= dis0_next;
      dis1_reg <= dis1_next;
      res_reg <= res_next;
      seeded_reg <= seeded_next;
      state_reg <= state_next;
      chan_reg <= chan_next;
      start_reg <= start_next;
      alert_reg <= alert_next;
      passdone_reg <= passdone_next;
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign CONV_ENABLE = ctrl_reg[BIT_CONV_ON];
  assign CONV_SPEED = ctrl_reg[BIT_SPEED_HI:BIT_SPEED_LO];
  assign CONV_BITS = 4'hf - {2'b00, ctrl_reg[BIT_SPEED_HI:BIT_SPEED_LO]};
  assign CONV_START = start_reg;
  assign CONV_CHANNEL = chan_reg;
  assign PASS_DONE = passdone_reg;
  assign HOST_ALERT = alert_reg;
endmodule
`default_nettype wire

// file: include/adcctl_pkg.sv
// package of register offsets, fields, reset values and sequencer states for the converter control block
package adcctl_pkg;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'h2e;
  localparam logic [7:0] ADDR_CHANNEL_DISABLE_FIRST = 8'h2f;
  localparam logic [7:0] ADDR_CHANNEL_DISABLE_SECOND = 8'h30;
  localparam logic [7:0] ADDR_INPUT_CURRENT_RESULT = 8'h31;
  localparam logic [7:0] ADDR_BATTERY_CURRENT_RESULT = 8'h33;
  localparam logic [7:0] ADDR_BUS_VOLTAGE_RESULT = 8'h35;
  localparam logic [7:0] ADDR_SOURCE_ONE_VOLTAGE_RESULT = 8'h37;

  localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h30;
  localparam logic [7:0] RST_CHANNEL_DISABLE = 8'h00;
  localparam logic [15:0] RST_RESULT = 16'h0000;

  localparam int BIT_CONV_ON = 7;
  localparam int BIT_RATE_SELECT = 6;
  localparam int BIT_SPEED_HI = 5;
  localparam int BIT_SPEED_LO = 4;
  localparam int BIT_AVERAGING_SELECT = 3;
  localparam int BIT_AVERAGE_SEED_SELECT = 2;

  localparam logic [7:0] MASK_CONVERTER_CONTROL = 8'hfc;
  localparam logic [7:0] MASK_CHANNEL_DISABLE_FIRST = 8'hfe;
  localparam logic [7:0] MASK_CHANNEL_DISABLE_SECOND = 8'hf0;

  // result channel index
  localparam int CH_INPUT_CURRENT = 0;
  localparam int CH_BATTERY_CURRENT = 1;
  localparam int CH_BUS_VOLTAGE = 2;
  localparam int CH_SOURCE_ONE = 3;
  localparam int NUM_RESULTS = 4;

  // averaging weight shift: new = old + (sample - old) / 2**AVG_SHIFT
  localparam int AVG_SHIFT = 2;

  typedef enum logic [3:0] {
    ADCCTL_IDLE = 4'b0001,
    ADCCTL_START = 4'b0010,
    ADCCTL_WAIT = 4'b0100,
    ADCCTL_NEXT = 4'b1000
  } adcctl_state_e;
endpackage

// file: design/adcctl_average.sv
// running average / single value filter for one converter result word
`timescale 1ns/1ps
`default_nettype none
module adcctl_average #(
  parameter int WIDTH = 16,
  parameter int SHIFT = 2
) (
  input wire logic [WIDTH-1:0] old_value,
  input wire logic [WIDTH-1:0] sample,
  input wire logic averaging,
  input wire logic seed_fresh,
  input wire logic first_pass,
  output logic [WIDTH-1:0] result
);
  logic signed [WIDTH:0] diff;
  logic signed [WIDTH:0] step;
  always_comb begin
    diff = $signed({sample[WIDTH-1], sample}) - $signed({old_value[WIDTH-1], old_value});
    step = diff >>> SHIFT;
    if (!averaging) begin
      result = sample;
    end else if (first_pass && seed_fresh) begin
      result = sample;
    end else begin
      result = WIDTH'($signed({old_value[WIDTH-1], old_value}) + step);
    end
  end
endmodule
`default_nettype wire

// file: verif/adcctl_sva.sv
// port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcctl_sva #(
  parameter int WIDTH = 16
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic REG_RESET_CMD,
  input wire logic WATCHDOG_EXPIRED,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WRITE,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_READ,
  input wire logic [7:0] REG_RDATA,
  input wire logic DONE_MASK,
  input wire logic DISCHARGE_SENSE_ENABLE,
  input wire logic CONV_ENABLE,
  input wire logic [1:0] CONV_SPEED,
  input wire logic [3:0] CONV_BITS,
  input wire logic CONV_START,
  input wire logic [3:0] CONV_CHANNEL,
  input wire logic CONV_DONE,
  input wire logic [WIDTH-1:0] CONV_DATA,
  input wire logic PASS_DONE,
  input wire logic HOST_ALERT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  run_gate_a: assert property (
    CONV_START |-> CONV_ENABLE || $past(CONV_ENABLE)) else $error("start while off");
  res_map_a: assert property (
    CONV_BITS == 4'hf - {2'h0, CONV_SPEED}) else $error("resolution mismatch");
  wdog_off_a: assert property (
    WATCHDOG_EXPIRED |=> !CONV_ENABLE) else $error("watchdog left converter on");
  cmd_reset_a: assert property (
    REG_RESET_CMD |=> !CONV_ENABLE && CONV_SPEED == 2'h3) else $error("reset command missed");
  alert_mask_a: assert property (
    HOST_ALERT |-> PASS_DONE && !$past(DONE_MASK)) else $error("bad alert");
  oneshot_stop_a: assert property (
    HOST_ALERT |-> ##[0:1] !CONV_ENABLE) else $error("one-shot did not stop");
  start_space_a: assert property (
    CONV_START |=> !CONV_START [*3]) else $error("starts too close");
  chan_legal_a: assert property (
    CONV_START |-> CONV_CHANNEL <= 4'ha) else $error("illegal channel");
  reserved_rd_a: assert property (
    REG_READ && REG_ADDR == 8'h30 |=> ##[0:1] REG_RDATA[3:0] == 4'h0) else $error("reserved set");
  unmapped_rd_a: assert property (
    REG_READ && REG_ADDR > 8'h38 |=> ##[0:1] REG_RDATA == 8'h00) else $error("unmapped read");
  alert_c: cover property (HOST_ALERT);
  cont_pass_c: cover property (PASS_DONE && CONV_ENABLE);
  wdog_c: cover property (WATCHDOG_EXPIRED && CONV_ENABLE);
endmodule
bind adcctl_top adcctl_sva #(.WIDTH(WIDTH)) adcctl_sva_i (.*);
`default_nettype wire

// file: verif/adcctl_conv_model.sv
// behavioural converter answering each start pulse with a per-channel value
`timescale 1ns/1ps
`default_nettype none
module adcctl_conv_model (
  input wire logic CLK_SYS,
  input wire logic CONV_START,
  input wire logic [3:0] CONV_CHANNEL,
  input wire logic slow,
  output logic CONV_DONE,
  output logic [15:0] CONV_DATA
);
  int t = -1;
  int lat;
  logic [15:0] val = 16'h0000;
  always @(posedge CLK_SYS) begin
    if (CONV_START) begin
      t <= 0;
      case (CONV_CHANNEL)
        4'h0: val <= 16'hfc18;
        4'h1: val <= 16'hff38;
        4'h2: val <= 16'h1388;
        4'ha: val <= 16'h0bb8;
        default: val <= 16'h0123;
      endcase
    end else if (t >= 0 && t < 20) begin
      t <= t + 1;
    end else begin
      t <= -1;
    end
  end
  assign lat = slow ? 9 : 1;
  // data is only held while done is high, scrambled otherwise
  assign CONV_DONE = (t >= lat) && (t < lat + 4);
  assign CONV_DATA = CONV_DONE ? val : ~val ^ 16'(t);
endmodule
`default_nettype wire

// file: verif/adcctl_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcctl_test;
  import adcctl_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  logic REG_RESET_CMD = 1'b0;
  logic WATCHDOG_EXPIRED = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic REG_WRITE = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_READ = 1'b0;
  logic DONE_MASK = 1'b0;
  logic DISCHARGE_SENSE_ENABLE = 1'b0;
  logic slow = 1'b0;
  logic [7:0] REG_RDATA;
  logic CONV_ENABLE, CONV_START, CONV_DONE, PASS_DONE, HOST_ALERT;
  logic [1:0] CONV_SPEED;
  logic [3:0] CONV_BITS, CONV_CHANNEL;
  logic [15:0] CONV_DATA;
  int err_total = 0;
  int n_tests = 0;
  int starts = 0;
  always #20 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) if (CONV_START === 1'b1) starts <= starts + 1;
  adcctl_top adcctl_top_i (.*);
  adcctl_conv_model adcctl_conv_model_i (.*);
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge CLK_SYS);
    s = 1'b1;
    @(negedge CLK_SYS);
    s = 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge CLK_SYS);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WRITE = 1'b1;
    @(negedge CLK_SYS);
    REG_WRITE = 1'b0;
  endtask
  task automatic rchk(logic [7:0] a, logic [7:0] e);
    @(negedge CLK_SYS);
    REG_ADDR = a;
    REG_READ = 1'b1;
    @(negedge CLK_SYS);
    REG_READ = 1'b0;
    @(negedge CLK_SYS);
    chk("register byte", {8'h00, REG_RDATA}, {8'h00, e});
  endtask
  // high byte sits at the lower address
  task automatic rword(logic [7:0] a, logic [15:0] e);
    rchk(a, e[15:8]);
    rchk(8'(a + 8'h01), e[7:0]);
  endtask
  task automatic wait_pass(logic al_exp);
    logic al = 1'b0;
    int i = 0;
    repeat (600) begin
      @(negedge CLK_SYS);
      al |= HOST_ALERT;
      if (PASS_DONE === 1'b1) break;
      i++;
    end
    if (i == 600) begin
      chk("pass finished", 16'h0000, 16'h0001);
      final_report();
    end else begin
      repeat (2) @(negedge CLK_SYS) al |= HOST_ALERT;
      chk("host alert", {15'h0000, al}, {15'h0000, al_exp});
    end
  endtask
  task automatic t_reset();
    rchk(ADDR_CONVERTER_CONTROL, 8'h30);
    rchk(ADDR_CHANNEL_DISABLE_FIRST, 8'h00);
    rchk(ADDR_CHANNEL_DISABLE_SECOND, 8'h00);
    chk("resolution", {12'h000, CONV_BITS}, 16'h000c);
    for (int a = 8'h31; a <= 8'h37; a += 2) rword(8'(a), 16'h0000);
    wr(ADDR_BUS_VOLTAGE_RESULT, 8'hff);
    wr(ADDR_SOURCE_ONE_VOLTAGE_RESULT, 8'hff);
    rword(ADDR_BUS_VOLTAGE_RESULT, 16'h0000);
    rword(ADDR_SOURCE_ONE_VOLTAGE_RESULT, 16'h0000);
    rchk(8'h3a, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_fields();
    wr(ADDR_CHANNEL_DISABLE_FIRST, 8'hff);
    wr(ADDR_CHANNEL_DISABLE_SECOND, 8'hff);
    wr(ADDR_CONVERTER_CONTROL, 8'h7f);
    rchk(ADDR_CHANNEL_DISABLE_FIRST, 8'hfe);
    rchk(ADDR_CHANNEL_DISABLE_SECOND, 8'hf0);
    rchk(ADDR_CONVERTER_CONTROL, 8'h7c);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CONVERTER_CONTROL, 8'(s << 4));
      chk("resolution", {12'h000, CONV_BITS}, 16'(15 - s));
    end
    wr(ADDR_CONVERTER_CONTROL, 8'h7c);
    pulse(REG_RESET_CMD);
    rchk(ADDR_CHANNEL_DISABLE_FIRST, 8'h00);
    rchk(ADDR_CHANNEL_DISABLE_SECOND, 8'h00);
    rchk(ADDR_CONVERTER_CONTROL, 8'h30);
    $display("field test done");
  endtask
  task automatic t_oneshot();
    wr(ADDR_CHANNEL_DISABLE_FIRST, 8'h1e);
    wr(ADDR_CHANNEL_DISABLE_SECOND, 8'he0);
    starts = 0;
    wr(ADDR_CONVERTER_CONTROL, 8'hc0);
    wait_pass(1'b1);
    chk("conversions", 16'(starts), 16'h0004);
    rchk(ADDR_CONVERTER_CONTROL, 8'h40);
    rword(ADDR_INPUT_CURRENT_RESULT, 16'hfc18);
    rword(ADDR_BATTERY_CURRENT_RESULT, 16'h0000);
    rword(ADDR_BUS_VOLTAGE_RESULT, 16'h1388);
    rword(ADDR_SOURCE_ONE_VOLTAGE_RESULT, 16'h0bb8);
    slow = 1'b1;
    DISCHARGE_SENSE_ENABLE = 1'b1;
    DONE_MASK = 1'b1;
    starts = 0;
    wr(ADDR_CONVERTER_CONTROL, 8'hc0);
    wait_pass(1'b0);
    chk("conversions", 16'(starts), 16'h0004);
    rword(ADDR_BATTERY_CURRENT_RESULT, 16'hff38);
    $display("one-shot test done");
  endtask
  task automatic t_cont();
    DONE_MASK = 1'b0;
    slow = 1'b0;
    wr(ADDR_CONVERTER_CONTROL, 8'h8c);
    wait_pass(1'b0);
    wait_pass(1'b0);
    chk("enable", {15'h0000, CONV_ENABLE}, 16'h0001);
    pulse(WATCHDOG_EXPIRED);
    chk("enable", {15'h0000, CONV_ENABLE}, 16'h0000);
    rchk(ADDR_CONVERTER_CONTROL, 8'h0c);
    rword(ADDR_INPUT_CURRENT_RESULT, 16'hfc18);
    pulse(RESET);
    rchk(ADDR_CONVERTER_CONTROL, 8'h30);
    rword(ADDR_INPUT_CURRENT_RESULT, 16'h0000);
    $display("continuous test done");
  endtask
  // results start from zero after reset; a quarter step toward each sample
  task automatic t_average();
    wr(ADDR_CONVERTER_CONTROL, 8'hc8);
    wait_pass(1'b1);
    rword(ADDR_INPUT_CURRENT_RESULT, 16'hff06);
    rword(ADDR_BATTERY_CURRENT_RESULT, 16'hffce);
    rword(ADDR_BUS_VOLTAGE_RESULT, 16'h04e2);
    rword(ADDR_SOURCE_ONE_VOLTAGE_RESULT, 16'h02ee);
    wr(ADDR_CONVERTER_CONTROL, 8'hcc);
    wait_pass(1'b1);
    rword(ADDR_INPUT_CURRENT_RESULT, 16'hfc18);
    rword(ADDR_BUS_VOLTAGE_RESULT, 16'h1388);
    $display("average test done");
  endtask
  initial begin
    repeat (2) @(negedge CLK_SYS);
    RESET = 1'b0;
    t_reset();
    t_fields();
    t_oneshot();
    t_cont();
    t_average();
    final_report();
  end
endmodule
`default_nettype wire
